// ---- adc_seq_pkg.sv ----
package adc_seq_pkg;
	localparam int MCLK_PERIOD_NS = 40;
	// Longest clock stretch allowed per converted channel
	localparam int STRETCH_MAX_NS = 8300;
	localparam int STRETCH_CYCLES = STRETCH_MAX_NS / MCLK_PERIOD_NS;
	// Two cycles of each channel go to sampling and storing
	localparam logic [7:0] CONV_COUNT = 8'(STRETCH_CYCLES - 2);
	localparam logic [4:0] EXT_SAMPLE_SCL = 5'h02;
	localparam logic [4:0] EXT_CONV_SCL = 5'h10;
	localparam logic [4:0] EXT_TOTAL_SCL = EXT_SAMPLE_SCL + EXT_CONV_SCL;
	localparam int RESULT_W = 12;
	localparam int MEM_DEPTH = 12;
	localparam logic [3:0] MEM_LAST = 4'hB;
	localparam logic [3:0] CH_GND = 4'hF;
	localparam logic [3:0] CH_MAX = 4'hB;
	localparam logic [3:0] CH_REF_CAP_4 = 4'h2;
	localparam logic [3:0] CH_REF_CAP_12 = 4'hA;
	localparam logic [3:0] CH_UPPER_4 = 4'h2;
	localparam logic [3:0] CH_UPPER_8_12 = 4'h6;
	localparam logic [3:0] REPEAT_LAST = 4'h7;
	localparam logic [3:0] HIGH_NIBBLE = 4'hF;
	localparam logic [1:0] SCAN_UP = 2'h0;
	localparam logic [1:0] SCAN_REPEAT = 2'h1;
	localparam logic [1:0] SCAN_UPPER = 2'h2;
	localparam logic [1:0] SCAN_SINGLE = 2'h3;
	localparam logic [6:0] ADDR_RESET = 7'h00;
	localparam logic RESET_SINGLE_ENDED = 1'b1;
	localparam logic RESET_CLOCK_MODE = 1'b0;

	typedef enum logic [1:0] {VAR_4CH, VAR_8CH, VAR_12CH} variant_t;

	typedef struct packed {
		variant_t variant;
		logic [6:0] slave_address;
		logic clock_mode_select;
		logic reference_pin_select_bit;
		logic single_ended_select;
		logic [1:0] scan_mode;
		logic [3:0] channel_select_field;
	} cfg_t;

	typedef struct packed {
		logic [3:0] pos;
		logic [3:0] neg;
		logic reserved;
	} pair_t;

	typedef enum {S_IDLE, S_ADDR, S_ADDR_ACK, S_STRETCH, S_SEND, S_GET_ACK, S_ACKED, S_WAIT} i2c_state_t;
endpackage : adc_seq_pkg

// ---- sync_2ff.sv ----
`timescale 1ns/100ps
module sync_2ff #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic ce,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge clk) begin
		if (ce) begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : sync_2ff

// ---- chan_pair_map.sv ----
`timescale 1ns/100ps
module chan_pair_map import adc_seq_pkg::*; (
	input wire logic [3:0] code,
	input wire logic single_ended_select,
	input wire logic reference_pin_select_bit,
	input wire variant_t variant,
	output pair_t pair
);
	wire ref_pair_4 = (variant == VAR_4CH) && (code[3:1] == 3'h1);
	wire ref_pair_12 = (variant == VAR_12CH) && (code[3:1] == 3'h5);
	// The shared pin is a reference here, so the pair reads ground against its analog partner
	wire ref_pair = ~single_ended_select & reference_pin_select_bit & (ref_pair_4 | ref_pair_12);
	wire [3:0] even_code = {code[3:1], 1'b0};

	// Odd code puts the upper input positive, even code the lower
	assign pair.pos = ref_pair ? CH_GND : code;
	assign pair.neg = single_ended_select ? CH_GND : (ref_pair ? even_code : (code ^ 4'h1));
	assign pair.reserved = (code[3:2] == 2'h3);
endmodule : chan_pair_map

// ---- adc_i2c_conversion_read_sequencer.sv ----
// Function
// - Differential codes pick adjacent pairs; odd code upper positive; top bits both set reserved.
// - Four-channel parts zero two upper select bits; eight-channel parts zero the top one.
// - Reference select set: pair with shared pin reads ground against third or eleventh input.
// - With shared pin as reference, code 1011 returns minus eleventh input.
// - Differential scans step channel address by two up to limit from upper three bits.
// - Master reads with start, address, read bit one; device acknowledges a good address.
// - Each result is two bytes: four high bits, then result MSB first.
// - Master acks to continue or nacks to stop; on nack device releases SDA.
// - Clock-mode bit resets to zero, selecting the internal oscillator.
// - Internal mode: track on eighth rising SCL edge, convert on ninth falling edge.
// - Internal mode: hold SCL low through all scan conversions, release when stored.
// - Memory keeps 12-bit results in conversion order; internal repeat scans store eight of one channel.
// - Internal mode stretches SCL at most 8.3 us per converted channel.
// - Reference select set: scans skip the shared pin, except on dedicated-reference parts.
// - Results read first in first out; reading past the last wraps to first.
// - Reads return current results; new conversions need a new addressed read.
// - Clock-mode bit set: SCL is the conversion clock.
// - External mode: track on ninth rising SCL edge, convert two SCL cycles later; the code converts after the fourth SCL rise past it.
// - External mode: repeat and single scans convert until the master nacks.
// - Scan 00 converts from first input up to the selected channel.
// - Single-ended select one means single-ended inputs, zero means differential pairs.
`timescale 1ns/100ps
module adc_i2c_conversion_read_sequencer import adc_seq_pkg::*; (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic scl_clk,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire cfg_t cfg,
	input wire logic [RESULT_W-1:0] conv_data,
	output logic track,
	output logic sample_convert,
	output pair_t conv_pair,
	output logic busy,
	output logic reserved_code
);
	i2c_state_t st;
	cfg_t cfg_l;
	logic [1:0] pin_s;
	logic scl_d, sda_d;
	logic [3:0] bit_cnt;
	logic [7:0] shreg, tx;
	logic lo_byte;
	logic [3:0] rd_ptr, wr_ptr, n_stored, cur_code, rep_cnt;
	logic [7:0] conv_cnt;
	logic int_busy, ext_run;
	logic [RESULT_W-1:0] mem [MEM_DEPTH];
	logic [1:0] lk_s, ev_s, ev_d;
	logic [4:0] lk_cnt;
	logic sample_tog, done_tog;
	pair_t pair_now;

	// Pin inputs pass two flops before any edge logic reads them
	sync_2ff #(.W(2)) u_pin_sync (
		.clk(mclk),
		.ce(ce),
		.d({scl_in, sda_in}),
		.q(pin_s)
	);
	wire scl_s = pin_s[1];
	wire sda_s = pin_s[0];
	wire scl_rise = scl_s & ~scl_d;
	wire scl_fall = ~scl_s & scl_d;
	wire start_c = scl_s & scl_d & sda_d & ~sda_s;
	wire stop_c = scl_s & scl_d & ~sda_d & sda_s;
	wire [7:0] addr_byte = {shreg[6:0], sda_s};
	wire addr_hit = (addr_byte == {cfg.slave_address, 1'b1});
	wire ext_mode = cfg_l.clock_mode_select;
	wire eighth_rise = (st == S_ADDR) && scl_rise && (bit_cnt == 4'h7) && addr_hit;
	wire ninth_rise = (st == S_ADDR_ACK) && scl_rise && (bit_cnt == 4'h9);
	wire ninth_fall = (st == S_ADDR_ACK) && scl_fall && (bit_cnt == 4'h9);
	wire nack_seen = (st == S_GET_ACK) && scl_rise && sda_s;
	wire frame_end = start_c | stop_c | nack_seen;

	// Select bits that do not exist on the smaller variants read as zero
	wire [3:0] cs_m = (cfg_l.variant == VAR_4CH) ? {2'h0, cfg_l.channel_select_field[1:0]} :
		(cfg_l.variant == VAR_8CH) ? {1'h0, cfg_l.channel_select_field[2:0]} : cfg_l.channel_select_field;
	wire sgl = cfg_l.single_ended_select;
	wire ref_excl = cfg_l.reference_pin_select_bit && (cfg_l.variant != VAR_8CH);
	wire [3:0] ref_cap = (cfg_l.variant == VAR_4CH) ? CH_REF_CAP_4 : CH_REF_CAP_12;
	wire [3:0] ref_cap_diff = {ref_cap[3:1] - 3'h1, cs_m[0]};
	wire [3:0] cs_cap = (cs_m > CH_MAX) ? CH_MAX : cs_m;
	wire [3:0] top_code = ref_excl ? (sgl ? ((cs_cap > ref_cap) ? ref_cap : cs_cap) :
		((cs_cap[3:1] >= ref_cap[3:1]) ? ref_cap_diff : cs_cap)) : cs_cap;
	wire [3:0] upper_base = (cfg_l.variant == VAR_4CH) ? CH_UPPER_4 : CH_UPPER_8_12;
	wire [3:0] upper_first = sgl ? upper_base : {upper_base[3:1], cs_m[0]};
	wire multi = (cfg_l.scan_mode == SCAN_UP) || (cfg_l.scan_mode == SCAN_UPPER);
	wire [3:0] first_code = (cfg_l.scan_mode == SCAN_UP) ? (sgl ? 4'h0 : {3'h0, cs_m[0]}) :
		(cfg_l.scan_mode == SCAN_UPPER) ? upper_first : cs_m;
	wire [3:0] last_code = !multi ? cs_m : ((top_code < first_code) ? first_code : top_code);
	wire [3:0] step = sgl ? 4'h1 : 4'h2;
	wire at_last = sgl ? (cur_code >= last_code) : (cur_code[3:1] >= last_code[3:1]);
	wire perpetual = ext_mode && !multi;
	wire int_last = (cfg_l.scan_mode == SCAN_REPEAT) ? (rep_cnt == REPEAT_LAST) :
		(cfg_l.scan_mode == SCAN_SINGLE) ? 1'b1 : at_last;
	wire [3:0] next_code = cur_code + step;

	wire ev_sample = ev_s[1] ^ ev_d[1];
	wire ev_done = ev_s[0] ^ ev_d[0];
	wire int_store = int_busy && (conv_cnt == 8'h01);
	wire ext_store = ext_run && ev_done;
	wire mem_we = int_store | ext_store;
	wire [3:0] next_wr = (wr_ptr == MEM_LAST) ? 4'h0 : wr_ptr + 4'h1;
	wire [3:0] next_rd = (rd_ptr + 4'h1 >= n_stored) ? 4'h0 : rd_ptr + 4'h1;
	wire [RESULT_W-1:0] rd_word = mem[rd_ptr];
	wire [7:0] next_tx = lo_byte ? rd_word[7:0] : {HIGH_NIBBLE, rd_word[11:8]};

	chan_pair_map u_map (
		.code(cur_code),
		.single_ended_select(sgl),
		.reference_pin_select_bit(cfg_l.reference_pin_select_bit),
		.variant(cfg_l.variant),
		.pair(pair_now)
	);

	always_ff @(posedge mclk) begin
		if (rst) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			ev_d <= 2'h0;
		end else if (ce) begin
			scl_d <= scl_s;
			sda_d <= sda_s;
			ev_d <= ev_s;
		end
	end

	// Configuration is frozen at each addressed read so a scan sees one consistent setting
	always_ff @(posedge mclk) begin
		if (rst) begin
			cfg_l <= '0;
			cfg_l.variant <= VAR_12CH;
			cfg_l.slave_address <= ADDR_RESET;
			cfg_l.single_ended_select <= RESET_SINGLE_ENDED;
			cfg_l.clock_mode_select <= RESET_CLOCK_MODE;
		end else if (ce && eighth_rise) begin
			cfg_l <= cfg;
		end
	end

	// Bus engine: start and stop abort any transfer in progress
	always_ff @(posedge mclk) begin
		if (rst) begin
			st <= S_IDLE;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			tx <= 8'h00;
			sda_oe <= 1'b0;
			lo_byte <= 1'b0;
			rd_ptr <= 4'h0;
		end else if (ce) begin
			if (start_c) begin
				st <= S_ADDR;
				bit_cnt <= 4'h0;
				sda_oe <= 1'b0;
			end else if (stop_c) begin
				st <= S_IDLE;
				sda_oe <= 1'b0;
			end else begin
				case (st)
					S_ADDR: begin
						if (scl_rise) begin
							shreg <= addr_byte;
							bit_cnt <= bit_cnt + 4'h1;
							if (bit_cnt == 4'h7) begin
								st <= addr_hit ? S_ADDR_ACK : S_WAIT;
								bit_cnt <= 4'h8;
							end
						end
					end
					S_ADDR_ACK: begin
						if (scl_fall && bit_cnt == 4'h8) begin
							sda_oe <= 1'b1;
							bit_cnt <= 4'h9;
						end else if (ninth_fall) begin
							// The data byte counts its bits from zero, not on from the ack bit
							bit_cnt <= 4'h0;
							rd_ptr <= 4'h0;
							lo_byte <= 1'b0;
							if (ext_mode) begin
								st <= S_SEND;
								tx <= {HIGH_NIBBLE, 4'h0};
								sda_oe <= 1'b0;
							end else begin
								st <= S_STRETCH;
								sda_oe <= 1'b0;
							end
						end
					end
					S_STRETCH: begin
						if (!int_busy && conv_cnt == 8'h00 && n_stored != 4'h0) begin
							st <= S_SEND;
							tx <= next_tx;
							sda_oe <= ~next_tx[7];
						end
					end
					S_SEND: begin
						if (scl_fall) begin
							bit_cnt <= bit_cnt + 4'h1;
							if (bit_cnt == 4'h7) begin
								st <= S_GET_ACK;
								sda_oe <= 1'b0;
								bit_cnt <= 4'h0;
							end else begin
								tx <= {tx[6:0], 1'b0};
								sda_oe <= ~tx[6];
							end
						end
					end
					S_GET_ACK: begin
						if (scl_rise) begin
							st <= sda_s ? S_WAIT : S_ACKED;
							if (!sda_s) begin
								lo_byte <= ~lo_byte;
								if (lo_byte) begin
									rd_ptr <= next_rd;
								end
							end
						end
					end
					S_ACKED: begin
						if (scl_fall) begin
							st <= S_SEND;
							tx <= next_tx;
							sda_oe <= ~next_tx[7];
						end
					end
					S_WAIT: sda_oe <= 1'b0;
					default: st <= S_IDLE;
				endcase
			end
		end
	end

	// Held one cycle after the ninth fall so the master has already pulled SCL low
	always_ff @(posedge mclk) begin
		if (rst) begin
			scl_oe <= 1'b0;
			scl_out <= 1'b0;
			sda_out <= 1'b0;
		end else if (ce) begin
			scl_oe <= (st == S_STRETCH);
		end
	end

	// Conversion sequencer, internal oscillator or SCL timed
	always_ff @(posedge mclk) begin
		if (rst) begin
			int_busy <= 1'b0;
			ext_run <= 1'b0;
			conv_cnt <= 8'h00;
			cur_code <= 4'h0;
			rep_cnt <= 4'h0;
			wr_ptr <= 4'h0;
			n_stored <= 4'h0;
			track <= 1'b0;
			sample_convert <= 1'b0;
		end else if (ce) begin
			sample_convert <= 1'b0;
			if (eighth_rise && !cfg.clock_mode_select) begin
				track <= 1'b1;
			end
			if (ninth_rise && ext_mode) begin
				track <= 1'b1;
				ext_run <= 1'b1;
				cur_code <= first_code;
				wr_ptr <= 4'h0;
				n_stored <= 4'h0;
			end else if (ninth_fall && !ext_mode) begin
				int_busy <= 1'b1;
				sample_convert <= 1'b1;
				track <= 1'b0;
				conv_cnt <= CONV_COUNT;
				cur_code <= first_code;
				rep_cnt <= 4'h0;
				wr_ptr <= 4'h0;
				n_stored <= 4'h0;
			end else if (int_store) begin
				wr_ptr <= next_wr;
				n_stored <= n_stored + 4'h1;
				rep_cnt <= rep_cnt + 4'h1;
				if (int_last) begin
					int_busy <= 1'b0;
					conv_cnt <= 8'h00;
				end else begin
					if (cfg_l.scan_mode != SCAN_REPEAT) begin
						cur_code <= next_code;
					end
					sample_convert <= 1'b1;
					conv_cnt <= CONV_COUNT;
				end
			end else if (int_busy) begin
				conv_cnt <= conv_cnt - 8'h01;
			end
			if (ext_run && frame_end) begin
				ext_run <= 1'b0;
				track <= 1'b0;
			end else if (ext_run && ev_sample) begin
				sample_convert <= 1'b1;
				track <= 1'b0;
			end else if (ext_store) begin
				track <= 1'b1;
				if (perpetual) begin
					n_stored <= 4'h1;
				end else begin
					if (n_stored <= wr_ptr) begin
						n_stored <= wr_ptr + 4'h1;
					end
					wr_ptr <= at_last ? 4'h0 : next_wr;
					cur_code <= at_last ? first_code : next_code;
				end
			end
		end
	end

	// Result memory; contents are undefined until the first conversion
	always_ff @(posedge mclk) begin
		if (ce && mem_we) begin
			mem[wr_ptr] <= conv_data;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			conv_pair <= '0;
			busy <= 1'b0;
			reserved_code <= 1'b0;
		end else if (ce) begin
			conv_pair <= pair_now;
			busy <= int_busy | ext_run;
			reserved_code <= pair_now.reserved & (int_busy | ext_run);
		end
	end

	// SCL-timed conversion clock; it stops with the bus, so the run level restarts it each frame
	sync_2ff #(.W(2)) u_link_sync (
		.clk(scl_clk),
		.ce(1'b1),
		.d({rst, ext_run}),
		.q(lk_s)
	);

	always_ff @(posedge scl_clk) begin
		if (lk_s[1]) begin
			lk_cnt <= 5'h00;
			sample_tog <= 1'b0;
			done_tog <= 1'b0;
		end else if (!lk_s[0]) begin
			lk_cnt <= 5'h00;
		end else begin
			lk_cnt <= (lk_cnt == EXT_TOTAL_SCL - 5'h01) ? 5'h00 : lk_cnt + 5'h01;
			if (lk_cnt == EXT_SAMPLE_SCL - 5'h01) begin
				sample_tog <= ~sample_tog;
			end
			if (lk_cnt == EXT_TOTAL_SCL - 5'h01) begin
				done_tog <= ~done_tog;
			end
		end
	end

	sync_2ff #(.W(2)) u_event_sync (
		.clk(mclk),
		.ce(ce),
		.d({sample_tog, done_tog}),
		.q(ev_s)
	);
endmodule : adc_i2c_conversion_read_sequencer

// ---- adc_seq_checker_asserts.sv ----
`timescale 1ns/100ps
module adc_seq_checker import adc_seq_pkg::*; (
	input wire logic mclk,
	input wire logic rst,
	input wire logic scl_oe,
	input wire cfg_t cfg,
	input wire logic sample_convert,
	input wire pair_t conv_pair,
	input wire logic busy,
	input wire logic reserved_code
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	logic [8:0] held;
	wire int_mode = !cfg.clock_mode_select;
	wire diff12 = !cfg.single_ended_select && cfg.variant == VAR_12CH && cfg.scan_mode == SCAN_SINGLE;
	// Cycles of stretch since the last conversion start
	always_ff @(posedge mclk) begin
		held <= (rst || sample_convert || !scl_oe) ? 9'h000 : held + 9'h001;
	end
	a_stretch_bound: assert property (
		held <= 9'(STRETCH_CYCLES + 1)) else $error("stretch too long for one channel");
	a_stretch_hold: assert property (
		sample_convert && int_mode |-> ##[0:2] scl_oe [*8]) else $error("SCL not held during conversion");
	a_pulse_gap: assert property (
		sample_convert && int_mode |=> !sample_convert [*8]) else $error("conversions overlap");
	a_ext_free: assert property (
		cfg.clock_mode_select |-> !scl_oe) else $error("SCL stretched in external mode");
	a_convert_busy: assert property (
		sample_convert |=> busy) else $error("conversion while idle");
	// Pair, flag and busy are registered one cycle after the conversion start
	a_reserved_flag: assert property (
		sample_convert && !cfg.single_ended_select && cfg.variant == VAR_12CH
		|=> reserved_code == (cfg.channel_select_field[3:2] == 2'b11)) else $error("reserved flag wrong");
	a_pair_map: assert property (
		sample_convert && diff12 && !cfg.reference_pin_select_bit && cfg.channel_select_field < 4'hC
		|=> conv_pair.pos == cfg.channel_select_field && conv_pair.neg == (cfg.channel_select_field ^ 4'h1))
		else $error("differential pair wrong");
	a_ref_pair: assert property (
		sample_convert && diff12 && cfg.reference_pin_select_bit && cfg.channel_select_field[3:1] == 3'b101
		|=> conv_pair.pos == CH_GND && conv_pair.neg == CH_REF_CAP_12) else $error("reference pair wrong");
	a_mask_narrow: assert property (
		sample_convert && cfg.variant == VAR_4CH && cfg.single_ended_select && cfg.scan_mode == SCAN_SINGLE
		&& !cfg.reference_pin_select_bit |=> conv_pair.pos == {2'b00, cfg.channel_select_field[1:0]})
		else $error("upper select bits not forced");
endmodule : adc_seq_checker

bind adc_i2c_conversion_read_sequencer adc_seq_checker chk_u (.mclk(mclk), .rst(rst), .scl_oe(scl_oe),
	.cfg(cfg), .sample_convert(sample_convert), .conv_pair(conv_pair), .busy(busy), .reserved_code(reserved_code));

// ---- i2c_master_model.sv ----
`timescale 1ns/100ps
module i2c_master_model (
	input wire logic mclk,
	input wire logic scl_oe,
	input wire logic sda_oe,
	output logic scl,
	output logic sda
);
	// Half period of 8 cycles, 320 ns, gives SCL a 640 ns period, about 1.56 MHz
	localparam int HALF = 8;
	logic scl_m = 1'b1;
	logic sda_m = 1'b1;
	// Open-drain lines with pull-ups
	assign scl = scl_m & ~scl_oe;
	assign sda = sda_m & ~sda_oe;
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick
	task automatic pulse(input int n);
		repeat (n) begin
			scl_m = 1'b0;
			tick(2);
			scl_m = 1'b1;
			tick(2);
		end
	endtask : pulse
	task automatic start;
		sda_m = 1'b1;
		scl_m = 1'b1;
		tick(HALF);
		sda_m = 1'b0;
		tick(HALF);
		scl_m = 1'b0;
	endtask : start
	task automatic stop;
		sda_m = 1'b0;
		tick(HALF);
		scl_m = 1'b1;
		tick(HALF);
		sda_m = 1'b1;
		tick(HALF);
	endtask : stop
	// Waits out a stretch, but only for a bounded time
	task automatic xbit(input logic b, output logic r);
		sda_m = b;
		tick(HALF);
		scl_m = 1'b1;
		for (int n = 0; n < 4000 && scl !== 1'b1; n++)
			tick(1);
		tick(HALF);
		r = sda;
		scl_m = 1'b0;
	endtask : xbit
	task automatic xbyte(input logic [7:0] w, output logic [7:0] r);
		for (int i = 7; i >= 0; i--)
			xbit(w[i], r[i]);
	endtask : xbyte
endmodule : i2c_master_model

// ---- tb_adc_i2c_conversion_read_sequencer.sv ----
`timescale 1ns/100ps
module tb_adc_i2c_conversion_read_sequencer import adc_seq_pkg::*;;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [RESULT_W-1:0] conv_data = 12'h000;
	logic [RESULT_W-1:0] v;
	cfg_t cfg = '0;
	wire scl, sda, scl_oe, sda_oe, sample_convert;
	int failures = 0;
	int comparisons = 0;
	int cycles = 0;
	int pulses = 0;
	int seed = 78357;
	logic [RESULT_W-1:0] exp_q[$];
	always #20 mclk = ~mclk;
	i2c_master_model m_u (.mclk(mclk), .scl_oe(scl_oe), .sda_oe(sda_oe), .scl(scl), .sda(sda));
	adc_i2c_conversion_read_sequencer dut_u (.mclk(mclk), .rst(rst), .ce(1'b1), .scl_clk(scl), .scl_in(scl),
		.scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .cfg(cfg), .conv_data(conv_data),
		.track(), .sample_convert(sample_convert), .conv_pair(), .busy(), .reserved_code());
	// Converter stand-in: a fresh random result for every conversion start
	always @(posedge mclk) begin
		cycles++;
		if (sample_convert === 1'b1) begin
			v = 12'($random(seed));
			conv_data <= v;
			exp_q.push_back(v);
			pulses++;
		end
		if (cycles == 90000) begin
			failures++;
			end_sim;
		end
	end
	task automatic chk_v(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_v
	task automatic chk_b(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_b
	task automatic end_sim;
		$display("Counts: %0d comparisons, %0d failures", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_sim
	function automatic int nconv(input cfg_t c);
		logic [3:0] cs;
		logic [3:0] cap;
		cs = c.channel_select_field & (c.variant == VAR_4CH ? 4'h3 : c.variant == VAR_8CH ? 4'h7 : 4'hF);
		cap = c.variant == VAR_4CH ? CH_REF_CAP_4 : CH_REF_CAP_12;
		if (cs > CH_MAX)
			cs = CH_MAX;
		if (c.reference_pin_select_bit && c.variant != VAR_8CH) begin
			if (c.single_ended_select && cs > cap)
				cs = cap;
			else if (!c.single_ended_select && cs >= cap)
				cs = cap - 4'h1;
		end
		if (c.scan_mode == SCAN_SINGLE)
			return 1;
		return c.single_ended_select ? cs + 1 : cs / 2 + 1;
	endfunction : nconv
	task automatic frame(input cfg_t c, input int nres, input logic ok);
		logic r;
		logic [7:0] b;
		int n;
		cfg = c;
		pulses = 0;
		exp_q.delete();
		n = nconv(c);
		m_u.start();
		m_u.xbyte({c.slave_address ^ {6'h00, !ok}, 1'b1}, b);
		m_u.xbit(1'b1, r);
		chk_b(r, !ok);
		for (int k = 0; k < nres; k++) begin
			m_u.xbyte(8'hFF, b);
			if (!c.clock_mode_select)
				chk_v(b, {HIGH_NIBBLE, exp_q[k % n][11:8]});
			m_u.xbit(1'b0, r);
			m_u.xbyte(8'hFF, b);
			if (!c.clock_mode_select)
				chk_v(b, exp_q[k % n][7:0]);
			m_u.xbit(k == nres - 1, r);
		end
		m_u.tick(5);
		chk_b(sda_oe, 1'b0);
		if (ok && !c.clock_mode_select)
			chk_v(8'(pulses), 8'(n));
		else if (ok)
			chk_b(pulses > 0, 1'b1);
		m_u.stop();
		m_u.tick(4);
	endtask : frame
	initial begin
		cfg_t c;
		// SCL toggles under reset so the link-side flops flush; three rises reach the reset branch
		m_u.pulse(3);
		rst = 1'b0;
		m_u.tick(4);
		c = '0;
		c.slave_address = 7'($random(seed));
		c.single_ended_select = 1'b1;
		frame(c, 0, 1'b0);
		$display("Test wrong address done");
		c.variant = VAR_12CH;
		c.single_ended_select = 1'b0;
		c.scan_mode = SCAN_SINGLE;
		for (int k = 0; k < 14; k++) begin
			c.channel_select_field = 4'(k > 11 ? k - 2 : k);
			c.reference_pin_select_bit = k > 11;
			frame(c, 1, 1'b1);
		end
		$display("Test differential pairs done");
		c.variant = VAR_4CH;
		c.single_ended_select = 1'b1;
		c.reference_pin_select_bit = 1'b0;
		c.channel_select_field = 4'hE;
		frame(c, 1, 1'b1);
		c.scan_mode = SCAN_UP;
		c.channel_select_field = 4'hF;
		frame(c, 6, 1'b1);
		$display("Test narrow variant done");
		for (int k = 0; k < 6; k++) begin
			c.variant = variant_t'(2'($unsigned($random(seed)) % 3));
			{c.single_ended_select, c.reference_pin_select_bit, c.channel_select_field} = 6'($random(seed));
			if (c.variant == VAR_12CH && c.channel_select_field > CH_MAX)
				c.channel_select_field[2] = 1'b0;
			c.scan_mode = $random(seed) & 1 ? SCAN_SINGLE : SCAN_UP;
			frame(c, nconv(c) + 2, 1'b1);
		end
		$display("Test random scans done");
		c.clock_mode_select = 1'b1;
		c.scan_mode = SCAN_SINGLE;
		frame(c, 3, 1'b1);
		$display("Test external clock done");
		end_sim;
	end
endmodule : tb_adc_i2c_conversion_read_sequencer
